// *** verilog/clk_mode_defs.svh ***
// Purpose: constants for the system clock and power mode block
// Assumes: one 20 MHz clock, synchronous active-high reset
// Notes: fast and slow oscillators are modelled as enable pulses from dividers
`ifndef CLK_MODE_DEFS_SVH
`define CLK_MODE_DEFS_SVH

// ==========================================================
// Register map
`define ADDR_SYS_CLK_CTRL 2'h0
`define ADDR_FAST_OSC_CTRL 2'h1
`define ADDR_IRQ_STATUS 2'h2
`define ADDR_IRQ_MASK 2'h3

// ==========================================================
// Fields and reset values
`define SEL_LSB 5
`define SEL_LOW_CLK 3'h7
`define HID_BIT 1
`define SID_BIT 0
`define FREQ_LSB 2
`define FREQ_12MHZ 2'h1
`define STABLE_BIT 1
`define FEN_BIT 0
`define SYS_CLK_CTRL_RESET 8'h00
`define FOC_RESET 8'h01
`define IRQ_STABLE 0
`define IRQ_SWITCH 1
`define IRQ_WAKE 2
`define IRQ_W 3

// ==========================================================
// Timing
`define CLK_HZ 20_000_000
`define FAST_HZ 12_000_000
`define SLOW_HZ 32_000
`define SWITCH_PERIODS 4
`define STABLE_TIME_US 16
`define STABLE_CYCLES ((`STABLE_TIME_US * `CLK_HZ + 999_999) / 1_000_000)

`endif

// *** verilog/clk_mode_pkg.sv ***
// Purpose: types shared by the clock and power mode block
// Assumes: defines header included
// Notes: none
package clk_mode_pkg;
	typedef enum logic [2:0] {
		MODE_RUN,
		MODE_SLEEP,
		MODE_IDLE_LOW,
		MODE_IDLE_BOTH,
		MODE_IDLE_HIGH
	} pwr_mode_t;
	typedef enum logic [1:0] {
		SW_IDLE,
		SW_WAIT_CUR,
		SW_WAIT_TAR
	} sw_state_t;
endpackage : clk_mode_pkg

// *** verilog/rate_divider.sv ***
// Purpose: turns the system clock into a slower one-cycle enable pulse
// Assumes: enable gates counting, counter restarts when disabled
// Notes: ratio rounds to the nearest whole cycle
module rate_divider #(
	parameter int RATIO = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Control
	input wire logic enable,
	output logic tick
);
	localparam int CW = (RATIO > 1) ? $clog2(RATIO) : 1;
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;

	always_comb begin
		cnt_nxt = cnt_r;
		tick = 1'b0;
		if (enable) begin
			if (cnt_r == CW'(RATIO - 1)) begin
				cnt_nxt = '0;
				tick = 1'b1;
			end else begin
				cnt_nxt = cnt_r + 1'b1;
			end
		end else begin
			cnt_nxt = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
endmodule : rate_divider

// *** verilog/sys_clock_power_ctrl.sv ***
`include "clk_mode_defs.svh"
// Purpose: system clock select, halt modes and fast oscillator tracking
// Assumes: halt and wake are one-cycle pulses from same-clock logic
// Notes: clocks are enable pulses; the CPU advances on cpu_tick
module sys_clock_power_ctrl #(
	parameter int STABLE_CYC = `STABLE_CYCLES,
	parameter int FAST_DIV = (`CLK_HZ + `FAST_HZ / 2) / `FAST_HZ,
	parameter int SLOW_DIV = (`CLK_HZ + `SLOW_HZ / 2) / `SLOW_HZ
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Register port
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// CPU side
	input wire logic halt_req,
	input wire logic wake_req,
	input wire logic watchdog_enable,
	output logic cpu_tick,
	output logic high_clk_tick,
	output logic low_clk_tick,
	output logic slow_osc_clk_tick,
	output clk_mode_pkg::pwr_mode_t pwr_mode,
	output logic irq
);
	import clk_mode_pkg::*;

	// ==========================================================
	// Registers
	logic [2:0] sel_r, sel_nxt;
	logic hid_r, hid_nxt, sid_r, sid_nxt;
	logic [1:0] freq_r, freq_nxt;
	logic fen_r, fen_nxt;
	localparam int IRQ_W_L = `IRQ_W;
	logic [IRQ_W_L-1:0] ist_r, ist_nxt, imsk_r, imsk_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	localparam int SCW = $clog2(STABLE_CYC + 1);
	logic [SCW-1:0] stab_cnt_r, stab_cnt_nxt;
	logic stable_r, stable_nxt;
	pwr_mode_t mode_r, mode_nxt;
	sw_state_t sw_r, sw_nxt;
	logic [2:0] act_sel_r, act_sel_nxt;
	logic [2:0] wait_r, wait_nxt;
	logic [5:0] pre_r, pre_nxt;
	logic fast_raw, slow_raw, high_on, low_on, slow_osc_on;
	logic cur_tick, tar_tick, sw_done, stable_rise, woke;

	function automatic logic is_low(input logic [2:0] s);
		is_low = (s == `SEL_LOW_CLK);
	endfunction : is_low

	// ==========================================================
	// Oscillator models
	// slow osc in sleep
	assign slow_osc_on = (mode_r != MODE_SLEEP) || watchdog_enable;
	rate_divider #(.RATIO(SLOW_DIV)) u_slow (
		.clk(clk),
		.srst(srst),
		.enable(slow_osc_on),
		.tick(slow_raw)
	);
	rate_divider #(.RATIO(FAST_DIV)) u_fast (
		.clk(clk),
		.srst(srst),
		.enable(fen_r && stable_r),
		.tick(fast_raw)
	);

	always_comb begin
		unique case (mode_r)
			MODE_RUN: begin
				high_on = 1'b1;
				low_on = 1'b1;
			end
			MODE_SLEEP: begin
				high_on = 1'b0;
				low_on = 1'b0;
			end
			MODE_IDLE_LOW: begin
				high_on = 1'b0;
				low_on = 1'b1;
			end
			MODE_IDLE_BOTH: begin
				high_on = 1'b1;
				low_on = 1'b1;
			end
			MODE_IDLE_HIGH: begin
				high_on = 1'b1;
				low_on = 1'b0;
			end
			default: begin
				high_on = 1'b0;
				low_on = 1'b0;
			end
		endcase
	end
	// high clock for peripherals follows its enable
	assign high_clk_tick = fast_raw && high_on;
	assign low_clk_tick = slow_raw && low_on;
	assign slow_osc_clk_tick = slow_raw;

	// divided high clock or low clock
	function automatic logic src_tick(input logic [2:0] s, input logic [5:0] p,
		input logic f, input logic l);
		if (is_low(s)) begin
			src_tick = l;
		end else begin
			src_tick = f && ((p & ((6'h01 << s) - 6'h01)) == 6'h00);
		end
	endfunction : src_tick

	assign cur_tick = src_tick(act_sel_r, pre_r, fast_raw, slow_raw);
	assign tar_tick = src_tick(sel_r, pre_r, fast_raw, slow_raw);
	// only whole source periods reach the CPU
	assign cpu_tick = (mode_r == MODE_RUN) && cur_tick && (sw_r == SW_IDLE);
	assign pwr_mode = mode_r;
	assign reg_rdata = rdata_r;
	assign irq = |(ist_r & imsk_r);

	// ==========================================================
	// Switch sequencer
	always_comb begin
		sw_nxt = sw_r;
		act_sel_nxt = act_sel_r;
		wait_nxt = wait_r;
		pre_nxt = fast_raw ? pre_r + 6'h01 : pre_r;
		sw_done = 1'b0;
		unique case (sw_r)
			SW_IDLE: begin
				// change starts the count, no halt needed
				if (sel_r != act_sel_r) begin
					sw_nxt = SW_WAIT_CUR;
					wait_nxt = '0;
				end
			end
			SW_WAIT_CUR: begin
				if (cur_tick) begin
					wait_nxt = wait_r + 3'h1;
					// First tick only aligns, four whole periods follow it
					if (wait_r == 3'(`SWITCH_PERIODS)) begin
						sw_nxt = SW_WAIT_TAR;
					end
				end
			end
			SW_WAIT_TAR: begin
				// hand over on a target edge
				if (tar_tick) begin
					act_sel_nxt = sel_r;
					sw_nxt = SW_IDLE;
					sw_done = 1'b1;
				end
			end
		endcase
	end

	// ==========================================================
	// Power mode
	always_comb begin
		mode_nxt = mode_r;
		woke = 1'b0;
		if (mode_r == MODE_RUN) begin
			if (halt_req) begin
				unique case ({hid_r, sid_r})
					2'b00: mode_nxt = MODE_SLEEP;
					2'b01: mode_nxt = MODE_IDLE_LOW;
					2'b11: mode_nxt = MODE_IDLE_BOTH;
					2'b10: mode_nxt = MODE_IDLE_HIGH;
				endcase
			end
		// wake on wake_req at once, with no check of any oscillator
		end else if (wake_req) begin
			mode_nxt = MODE_RUN;
			woke = 1'b1;
		end
	end

	// ==========================================================
	// Stability tracking
	always_comb begin
		stab_cnt_nxt = stab_cnt_r;
		stable_nxt = stable_r;
		if (!fen_r) begin
			stable_nxt = 1'b0;
			stab_cnt_nxt = '0;
		end else if (reg_wr && reg_addr == `ADDR_FAST_OSC_CTRL && !fen_r) begin
			stable_nxt = 1'b0;
		end else if (!stable_r) begin
			if (stab_cnt_r == SCW'(STABLE_CYC - 1)) begin
				stable_nxt = 1'b1;
			end else begin
				stab_cnt_nxt = stab_cnt_r + 1'b1;
			end
		end
	end
	assign stable_rise = stable_nxt && !stable_r;

	// ==========================================================
	// Register file
	always_comb begin
		sel_nxt = sel_r;
		hid_nxt = hid_r;
		sid_nxt = sid_r;
		freq_nxt = freq_r;
		fen_nxt = fen_r;
		imsk_nxt = imsk_r;
		rdata_nxt = 8'h00;
		ist_nxt = ist_r;
		if (reg_wr) begin
			unique case (reg_addr)
				`ADDR_SYS_CLK_CTRL: begin
					sel_nxt = reg_wdata[`SEL_LSB +: 3];
					hid_nxt = reg_wdata[`HID_BIT];
					sid_nxt = reg_wdata[`SID_BIT];
				end
				`ADDR_FAST_OSC_CTRL: begin
					freq_nxt = reg_wdata[`FREQ_LSB +: 2];
					fen_nxt = reg_wdata[`FEN_BIT];
				end
				`ADDR_IRQ_STATUS: ist_nxt = ist_r & ~reg_wdata[IRQ_W_L-1:0];
				`ADDR_IRQ_MASK: imsk_nxt = reg_wdata[IRQ_W_L-1:0];
			endcase
		end
		// Set wins over a same-cycle clear
		if (stable_rise) ist_nxt[`IRQ_STABLE] = 1'b1;
		if (sw_done) ist_nxt[`IRQ_SWITCH] = 1'b1;
		if (woke) ist_nxt[`IRQ_WAKE] = 1'b1;
		if (reg_rd) begin
			unique case (reg_addr)
				`ADDR_SYS_CLK_CTRL: rdata_nxt = {sel_r, 3'h0, hid_r, sid_r};
				`ADDR_FAST_OSC_CTRL: rdata_nxt = {4'h0, freq_r, stable_r, fen_r};
				`ADDR_IRQ_STATUS: rdata_nxt = {5'h00, ist_r};
				`ADDR_IRQ_MASK: rdata_nxt = {5'h00, imsk_r};
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			sel_r <= 3'(`SYS_CLK_CTRL_RESET >> `SEL_LSB);
			hid_r <= 1'(`SYS_CLK_CTRL_RESET >> `HID_BIT);
			sid_r <= 1'(`SYS_CLK_CTRL_RESET >> `SID_BIT);
			freq_r <= 2'(`FOC_RESET >> `FREQ_LSB);
			fen_r <= 1'(`FOC_RESET >> `FEN_BIT);
			ist_r <= '0;
			imsk_r <= '0;
			rdata_r <= 8'h00;
			stab_cnt_r <= '0;
			stable_r <= 1'(`FOC_RESET >> `STABLE_BIT);
			mode_r <= MODE_RUN;
			sw_r <= SW_IDLE;
			act_sel_r <= 3'(`SYS_CLK_CTRL_RESET >> `SEL_LSB);
			wait_r <= 3'h0;
			pre_r <= 6'h00;
		end else begin
			sel_r <= sel_nxt;
			hid_r <= hid_nxt;
			sid_r <= sid_nxt;
			freq_r <= freq_nxt;
			fen_r <= fen_nxt;
			ist_r <= ist_nxt;
			imsk_r <= imsk_nxt;
			rdata_r <= rdata_nxt;
			stab_cnt_r <= stab_cnt_nxt;
			stable_r <= stable_nxt;
			mode_r <= mode_nxt;
			sw_r <= sw_nxt;
			act_sel_r <= act_sel_nxt;
			wait_r <= wait_nxt;
			pre_r <= pre_nxt;
		end
	end

	// ==========================================================
	// Assertions
	sequence halt_none_s;
		halt_req && mode_r == MODE_RUN && !hid_r && !sid_r;
	endsequence
	AST_SLEEP_ENTRY: assert property (@(posedge clk) disable iff (srst)
		halt_none_s |=> mode_r == MODE_SLEEP && !cpu_tick && !high_clk_tick)
		else $error("sleep not entered");
	AST_IDLE_LOW: assert property (@(posedge clk) disable iff (srst)
		mode_r == MODE_IDLE_LOW |-> !cpu_tick && !high_clk_tick)
		else $error("idle low gating wrong");
	AST_IDLE_BOTH: assert property (@(posedge clk) disable iff (srst)
		halt_req && mode_r == MODE_RUN && hid_r && sid_r |=> mode_r == MODE_IDLE_BOTH)
		else $error("idle both not entered");
	AST_IDLE_HIGH: assert property (@(posedge clk) disable iff (srst)
		mode_r == MODE_IDLE_HIGH |-> !cpu_tick && !low_clk_tick)
		else $error("idle high gating wrong");
	AST_SLOW_RC_OSC_SLEEP: assert property (@(posedge clk) disable iff (srst)
		mode_r == MODE_SLEEP && !watchdog_enable |-> !slow_osc_clk_tick)
		else $error("slow osc ran in sleep");
	AST_STABLE_OFF: assert property (@(posedge clk) disable iff (srst)
		!fen_r |=> !stable_r)
		else $error("stable held while disabled");
	AST_FAST_STABLE: assert property (@(posedge clk) disable iff (srst)
		high_clk_tick |-> stable_r)
		else $error("fast clock before stable");
	AST_SWITCH_HOLD: assert property (@(posedge clk) disable iff (srst)
		sw_r == SW_IDLE && sel_r != act_sel_r |=> !cpu_tick [*2])
		else $error("switch not delayed");
	AST_FEN_RESET: assert property (@(posedge clk)
		srst |=> fen_r)
		else $error("enable reset wrong");
	AST_RD_ZERO: assert property (@(posedge clk) disable iff (srst)
		reg_rd && reg_addr == `ADDR_SYS_CLK_CTRL |=> reg_rdata[4:2] == 3'h0)
		else $error("reserved bits nonzero");
endmodule : sys_clock_power_ctrl

// *** verification/sys_clock_power_ctrl_test.sv ***
// Purpose: self-checking bench for the clock select and power mode block
// Assumes: STABLE_CYC 8 and SLOW_DIV 16 shorten the run
// Notes: tick rates are judged by counting pulses over a window
`include "clk_mode_defs.svh"
module sys_clock_power_ctrl_test;
	timeunit 1ns;
	timeprecision 1ns;
	import clk_mode_pkg::*;
	localparam int SC = 8;
	localparam int FD = 2;
	localparam int SD = 16;
	logic clk = 0;
	logic srst = 1;
	logic [1:0] reg_addr = 2'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 0;
	logic reg_rd = 0;
	logic halt_req = 0;
	logic wake_req = 0;
	logic watchdog_enable = 0;
	logic [7:0] reg_rdata;
	logic cpu_tick, high_clk_tick, low_clk_tick, slow_osc_clk_tick, irq;
	pwr_mode_t pwr_mode;
	int num_errors = 0;
	int n_compared = 0;
	int cyc = 0;
	int nc, nh, nl, ns;
	logic [7:0] d;
	logic [7:0] v;
	logic h, l, wd;
	pwr_mode_t em;

	sys_clock_power_ctrl #(.STABLE_CYC(SC), .FAST_DIV(FD), .SLOW_DIV(SD)) sys_clock_power_ctrl_i (
		.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.halt_req(halt_req), .wake_req(wake_req), .watchdog_enable(watchdog_enable),
		.cpu_tick(cpu_tick), .high_clk_tick(high_clk_tick), .low_clk_tick(low_clk_tick),
		.slow_osc_clk_tick(slow_osc_clk_tick), .pwr_mode(pwr_mode), .irq(irq));

	// ==========================================================
	// Clock and hang guard
	always #25 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			num_errors++;
			tally_and_finish();
		end
	end

	// ==========================================================
	// Helpers
	task tally_and_finish;
		if (num_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task near(input string nm, input int e, input int g);
		n_compared++;
		if (g < e - 1 || g > e + 1) begin
			num_errors++;
			$display("mismatch %s expected %0d seen %0d", nm, e, g);
		end
	endtask : near
	task wr(input logic [1:0] a, input logic [7:0] x);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= x;
		reg_wr <= 1;
		@(posedge clk);
		reg_wr <= 0;
	endtask : wr
	task rd(input logic [1:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge clk);
		reg_rd <= 0;
		#1 d = reg_rdata;
	endtask : rd
	task cnt(input int n);
		nc = 0; nh = 0; nl = 0; ns = 0;
		repeat (n) begin
			@(negedge clk);
			nc += cpu_tick;
			nh += high_clk_tick;
			nl += low_clk_tick;
			ns += slow_osc_clk_tick;
		end
	endtask : cnt
	task pulse(input bit hlt);
		@(posedge clk);
		if (hlt) halt_req <= 1;
		else wake_req <= 1;
		@(posedge clk);
		halt_req <= 0;
		wake_req <= 0;
	endtask : pulse
	function automatic pwr_mode_t mode_of(input logic hi, input logic lo);
		if (hi && lo) return MODE_IDLE_BOTH;
		if (hi) return MODE_IDLE_HIGH;
		if (lo) return MODE_IDLE_LOW;
		return MODE_SLEEP;
	endfunction : mode_of

	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(50));
		repeat (16) @(posedge clk);
		srst <= 0;
		rd(`ADDR_SYS_CLK_CTRL);
		chk("sys_clk_reset", `SYS_CLK_CTRL_RESET, d);
		rd(`ADDR_FAST_OSC_CTRL);
		chk("foc_reset", `FOC_RESET, d);
		repeat (SC) @(posedge clk);
		rd(`ADDR_FAST_OSC_CTRL);
		chk("foc_stable", `FOC_RESET | 8'h02, d);
		wr(`ADDR_IRQ_MASK, 8'h01);
		@(negedge clk) chk("irq_on", 8'h01, {7'h0, irq});
		wr(`ADDR_IRQ_STATUS, 8'h01);
		@(negedge clk) chk("irq_off", 8'h00, {7'h0, irq});
		wr(`ADDR_IRQ_MASK, 8'h00);
		v = 8'($urandom);
		wr(`ADDR_SYS_CLK_CTRL, v);
		rd(`ADDR_SYS_CLK_CTRL);
		chk("sys_clk_rw", v & 8'he3, d);
		wr(`ADDR_FAST_OSC_CTRL, 8'hf5);
		rd(`ADDR_FAST_OSC_CTRL);
		chk("foc_rw", 8'h07, d);
		for (int s = 0; s < 8; s++) begin
			wr(`ADDR_SYS_CLK_CTRL, {3'(s), 5'h00});
			repeat (700) @(posedge clk);
			cnt(1024);
			if (s < 7) near("cpu_rate", nh >> s, nc);
			else near("cpu_slow", nl, nc);
		end
		wr(`ADDR_IRQ_STATUS, 8'h07);
		wr(`ADDR_SYS_CLK_CTRL, 8'h00);
		repeat (4 * SD - 4) @(posedge clk);
		rd(`ADDR_IRQ_STATUS);
		chk("switch_early", 8'h00, d & 8'h02);
		repeat (3 * SD) @(posedge clk);
		rd(`ADDR_IRQ_STATUS);
		chk("switch_done", 8'h02, d & 8'h02);
		wr(`ADDR_SYS_CLK_CTRL, 8'he0);
		repeat (700) @(posedge clk);
		wr(`ADDR_FAST_OSC_CTRL, 8'h04);
		cnt(64);
		chk("high_off", 8'h00, 8'(nh));
		wr(`ADDR_FAST_OSC_CTRL, 8'h05);
		rd(`ADDR_FAST_OSC_CTRL);
		chk("stable_clear", 8'h05, d);
		repeat (SC) @(posedge clk);
		rd(`ADDR_FAST_OSC_CTRL);
		chk("stable_set", 8'h07, d);
		cnt(64);
		near("high_on", 64 / FD, nh);
		wr(`ADDR_SYS_CLK_CTRL, 8'h00);
		repeat (700) @(posedge clk);
		for (int i = 0; i < 5; i++) begin
			h = i[1];
			l = i[0];
			wd = i[2];
			em = mode_of(h, l);
			wr(`ADDR_SYS_CLK_CTRL, {3'($urandom % 4), 3'h0, h, l});
			watchdog_enable <= wd;
			pulse(1);
			cnt(4 * SD);
			chk("mode", {5'h0, em}, {5'h0, pwr_mode});
			chk("cpu_stop", 8'h00, 8'(nc));
			chk("high_idle", {7'h0, h}, {7'h0, nh > 0});
			chk("low_idle", {7'h0, l}, {7'h0, nl > 0});
			chk("slow_osc", {7'h0, h | l | wd}, {7'h0, ns > 0});
			pulse(0);
			cnt(4 * SD);
			chk("wake_mode", {5'h0, MODE_RUN}, {5'h0, pwr_mode});
			chk("wake_cpu", 8'h01, {7'h0, nc > 0});
			rd(`ADDR_IRQ_STATUS);
			chk("wake_flag", 8'h04, d & 8'h04);
			wr(`ADDR_IRQ_STATUS, 8'h04);
		end
		tally_and_finish();
	end
endmodule : sys_clock_power_ctrl_test
